// ===== dv/tcs_adc_model.sv
// Behavioural converter on the far side of the scheduler
// Assumes one start pulse per conversion, same clock as the scheduler
`timescale 1ns/1ps
module tcs_adc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic adc_start_q,
   input wire logic adc_temp_q,
   input wire logic [1:0] adc_chan_q,
   input wire logic slow,
   output logic adc_done,
   output logic [11:0] adc_result
);
   // ****
   // Converter
   // ****
   int cnt_q;
   logic [11:0] val_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 0;
         val_q <= 12'h0;
      end else if (adc_start_q) begin
         cnt_q <= slow ? 12 : 4;
         val_q <= adc_temp_q ? 12'h0a0 + {10'h0, adc_chan_q} : 12'h555;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
   assign adc_done = (cnt_q == 1);
   // Result only valid with done
   assign adc_result = adc_done ? val_q : ~val_q;
endmodule

// ===== dv/tcs_checker.sv
// Port checks for the temperature conversion scheduler
// Assumes binding into tcs_scheduler
`timescale 1ns/1ps
module tcs_checker #(
   parameter int RES_W = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] isense_trip,
   input wire logic [1:0] supply_under,
   input wire logic [1:0] overrange_clear,
   input wire logic autocycle_mode,
   input wire logic [1:0] append_remote,
   input wire logic signed [RES_W-1:0] temp_offset,
   input wire logic adc_done,
   input wire logic [RES_W-1:0] adc_result,
   input wire logic [1:0] current_overrange_flag,
   input wire logic adc_start_q,
   input wire logic adc_temp_q,
   input wire logic host_ack_q,
   input wire logic [RES_W-1:0] temp_local_q,
   input wire logic [1:0] append_q,
   input wire logic [2:0] fresh_q
);
   // ****
   // Assertions
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   trip_sets_a: assert property ($rose(isense_trip[0]) |-> ##3 current_overrange_flag[0])
      else $error("flag not set by trip");
   under_sets_a: assert property ($rose(supply_under[1]) |-> ##3 current_overrange_flag[1])
      else $error("flag not set by undervoltage");
   flag_hold_a: assert property ($fell(current_overrange_flag[0]) |-> $past(overrange_clear[0], 2)
      || $past(overrange_clear[0], 3) || $past(overrange_clear[0], 4)) else $error("flag dropped");
   host_start_a: assert property (host_ack_q |-> adc_start_q && !adc_temp_q)
      else $error("ack without host start");
   fresh_cause_a: assert property (fresh_q != 3'h0 |-> $onehot(fresh_q) && $past(adc_done)
      && $past(adc_temp_q)) else $error("bad fresh pulse");
   host_keeps_a: assert property (adc_done && !adc_temp_q |=> fresh_q == 3'h0)
      else $error("host result stored");
   offset_add_a: assert property (fresh_q[0] |-> temp_local_q == RES_W'($past(adc_result)
      + $past(temp_offset))) else $error("offset wrong");
   append_gate_a: assert property (rst_n && $past(rst_n) |=> append_q ==
      ($past(autocycle_mode) ? 2'h0 : $past(append_remote))) else $error("append wrong");
endmodule
bind tcs_scheduler tcs_checker #(.RES_W(RES_W)) u_chk (.*);

// ===== dv/tcs_scheduler_tb.sv
// Self-checking bench for the temperature conversion scheduler
// Assumes tcs_adc_model as converter and a short integration slot
`timescale 1ns/1ps
module tcs_scheduler_tb;
   logic clk = 0, rst_n = 0, autocycle_mode = 0, host_req = 0, seq_slot = 1, slow = 0, adc_done;
   logic [1:0] isense_trip = 0, supply_under = 0, overrange_clear = 0, append_remote = 0;
   logic [1:0] current_overrange_flag, adc_chan_q, append_q;
   logic signed [11:0] temp_offset = 12'hffe;
   logic [11:0] adc_result, temp_local_q, temp_remote1_q, temp_remote2_q;
   logic adc_start_q, adc_temp_q, host_ack_q;
   logic [2:0] fresh_q;
   int num_errors = 0;
   int checks_done = 0;
   int acks = 0;
   tcs_scheduler #(.SLOT_CYCLES(20)) uut (.*);
   tcs_adc_model adc (.*);
   // ****
   // Helpers
   // ****
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (host_ack_q === 1'b1) acks++;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_fresh(output logic [2:0] f);
      f = 3'h0;
      for (int i = 0; i < 300 && f == 3'h0; i++) begin
         step(1);
         f = fresh_q;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_order();
      logic [2:0] f;
      for (int k = 0; k < 3; k++) begin
         wait_fresh(f);
         check({9'h0, f}, 12'h001 << k);
      end
      check(temp_local_q, 12'h09e);
      check(temp_remote1_q, 12'h09f);
      check(temp_remote2_q, 12'h0a0);
      $display("test order done");
   endtask
   task automatic t_ovr();
      isense_trip = 2'h1;
      step(1);
      isense_trip = 2'h0;
      step(4);
      check({10'h0, current_overrange_flag}, 12'h001);
      supply_under = 2'h2;
      step(12);
      supply_under = 2'h0;
      check({10'h0, current_overrange_flag}, 12'h003);
      overrange_clear = 2'h3;
      step(1);
      overrange_clear = 2'h0;
      step(5);
      check({10'h0, current_overrange_flag}, 12'h000);
      $display("test overrange done");
   endtask
   task automatic t_mode();
      logic [2:0] f;
      slow = 1'b1;
      host_req = 1'b1;
      append_remote = 2'h3;
      wait_fresh(f);
      check({11'h0, f != 3'h0}, 12'h001);
      check({10'h0, append_q}, 12'h003);
      autocycle_mode = 1'b1;
      seq_slot = 1'b0;
      step(20);
      wait_fresh(f);
      check({9'h0, f}, 12'h000);
      seq_slot = 1'b1;
      wait_fresh(f);
      check({11'h0, f != 3'h0}, 12'h001);
      check({10'h0, append_q}, 12'h000);
      check({11'h0, acks != 0}, 12'h001);
      host_req = 1'b0;
      $display("test modes done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_order();
      t_ovr();
      t_mode();
      give_verdict();
   end
   initial begin
      #50000;
      num_errors++;
      give_verdict();
   end
endmodule

// ===== rtl/tcs_consts.svh
// Constants for the temperature conversion scheduler
// Assumes inclusion by bare name from rtl files
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH
`define TCS_CLK_MHZ 200
`define TCS_PERIOD_MS 5
`define TCS_NUM_TCH 3
`define TCS_NUM_ISNS 2
`define TCS_RES_W 12
`define TCS_CH_LOCAL 2'h0
`define TCS_CH_REMOTE1 2'h1
`define TCS_CH_REMOTE2 2'h2
// Integration slot per channel: the period shared out in turn
`define TCS_SLOT_CYCLES ((`TCS_PERIOD_MS * 1000 * `TCS_CLK_MHZ) / `TCS_NUM_TCH)
`define TCS_CONV_CYCLES 600
// Conversion times allowed before a missing done pulse releases the converter
`define TCS_GUARD_CONVS 4
`endif

// ===== rtl/tcs_overrange.sv
// Latched overrange flag for one current sense channel
// Assumes trip inputs already synchronised to clk
`timescale 1ns/1ps
module tcs_overrange (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trip,
   input wire logic clear,
   output logic flag_q
);
   // Set wins over clear; only software clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (trip) begin
         flag_q <= 1'b1;
      end else if (clear) begin
         flag_q <= 1'b0;
      end
   end
endmodule

// ===== rtl/tcs_pkg.sv
// Types for the temperature conversion scheduler
// Assumes nothing of its surroundings
package tcs_pkg;
   typedef enum logic [1:0] {TCS_IDLE, TCS_HOST, TCS_TEMP} tcs_conv_t;
endpackage

// ===== rtl/tcs_scheduler.sv
// Temperature conversion scheduler and current overrange latches
// Assumes analog comparators and converter outside; pins are asynchronous
`timescale 1ns/1ps
`include "tcs_consts.svh"
module tcs_scheduler
   import tcs_pkg::*;
#(
   parameter int SLOT_CYCLES = `TCS_SLOT_CYCLES,
   parameter int CONV_CYCLES = `TCS_CONV_CYCLES,
   parameter int RES_W = `TCS_RES_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] isense_trip,
   input wire logic [1:0] supply_under,
   input wire logic [1:0] overrange_clear,
   input wire logic autocycle_mode,
   input wire logic host_req,
   input wire logic seq_slot,
   input wire logic [1:0] append_remote,
   input wire logic signed [RES_W-1:0] temp_offset,
   input wire logic adc_done,
   input wire logic [RES_W-1:0] adc_result,
   output logic [1:0] current_overrange_flag,
   output logic adc_start_q,
   output logic [1:0] adc_chan_q,
   output logic adc_temp_q,
   output logic host_ack_q,
   output logic [RES_W-1:0] temp_local_q,
   output logic [RES_W-1:0] temp_remote1_q,
   output logic [RES_W-1:0] temp_remote2_q,
   output logic [1:0] append_q,
   output logic [2:0] fresh_q
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [1:0] clr_sync1_q;
   logic [1:0] clr_sync2_q;
   // Trip and undervoltage pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {supply_under, isense_trip};
         sync2_q <= sync1_q;
      end
   end

   // Software clear strobes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_sync1_q <= 2'h0;
         clr_sync2_q <= 2'h0;
      end else begin
         clr_sync1_q <= overrange_clear;
         clr_sync2_q <= clr_sync1_q;
      end
   end

   // ****************************************
   // Overrange latches
   // ****************************************
   // Either comparator output sets the latch
   genvar gi;
   generate
      for (gi = 0; gi < `TCS_NUM_ISNS; gi++) begin : g_or
         tcs_overrange u_or (
            .clk(clk),
            .rst_n(rst_n),
            .trip(sync2_q[gi] | sync2_q[gi+2]),
            .clear(clr_sync2_q[gi]),
            .flag_q(current_overrange_flag[gi])
         );
      end
   endgenerate

   // ****************************************
   // Integration rotation
   // ****************************************
   logic [31:0] slot_cnt_q;
   logic [1:0] integ_ch_q;
   logic integ_end;
   assign integ_end = (slot_cnt_q == 32'(SLOT_CYCLES - 1));
   // Slot counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt_q <= 32'h0000_0000;
      end else if (integ_end) begin
         slot_cnt_q <= 32'h0000_0000;
      end else begin
         slot_cnt_q <= slot_cnt_q + 32'h0000_0001;
      end
   end

   // Channel now integrating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         integ_ch_q <= `TCS_CH_LOCAL;
      end else if (integ_end) begin
         integ_ch_q <= (integ_ch_q == `TCS_CH_REMOTE2) ? `TCS_CH_LOCAL : integ_ch_q + 2'h1;
      end
   end

   // ****************************************
   // Pending temperature requests
   // ****************************************
   logic [2:0] pend_q;
   logic [1:0] pick;
   logic have_pend;
   logic take_temp;
   logic take_host;
   tcs_conv_t conv_q;
   logic [1:0] rr_q;
   always_comb begin
      pick = rr_q;
      have_pend = 1'b0;
      // Search from rotation pointer so none starves
      for (int k = 0; k < `TCS_NUM_TCH; k++) begin
         if (!have_pend && pend_q[(int'(rr_q) + k) % `TCS_NUM_TCH]) begin
            have_pend = 1'b1;
            pick = 2'((int'(rr_q) + k) % `TCS_NUM_TCH);
         end
      end
   end

   // ****************************************
   // Take decision
   // ****************************************
   logic conv_free;
   logic slot_ok;
   assign conv_free = (conv_q == TCS_IDLE) || adc_done;
   // An idle converter is taken at once; at a done, command mode always takes it, autocycle only in a marked slot
   assign slot_ok = !autocycle_mode || seq_slot;
   always_comb begin
      take_temp = 1'b0;
      if (have_pend) begin
         if (conv_q == TCS_IDLE) begin
            take_temp = 1'b1;
         end else if (adc_done && slot_ok) begin
            take_temp = 1'b1;
         end
      end
   end

   // Host conversion only when no temperature request claims the converter
   always_comb begin
      take_host = 1'b0;
      if (!take_temp && host_req && conv_free) begin
         take_host = 1'b1;
      end
   end

   // Set by integration end, cleared when served
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 3'h0;
      end else begin
         for (int k = 0; k < `TCS_NUM_TCH; k++) begin
            if (integ_end && integ_ch_q == 2'(k)) begin
               pend_q[k] <= 1'b1;
            end else if (take_temp && pick == 2'(k)) begin
               pend_q[k] <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Rotation pointer
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rr_q <= `TCS_CH_LOCAL;
      end else if (take_temp) begin
         rr_q <= (pick == `TCS_CH_REMOTE2) ? `TCS_CH_LOCAL : pick + 2'h1;
      end
   end

   // ****************************************
   // Lost conversion guard
   // ****************************************
   // A missing done pulse would stall every channel for good
   logic [31:0] busy_cnt_q;
   logic conv_lost;
   assign conv_lost = (busy_cnt_q == 32'(`TCS_GUARD_CONVS * CONV_CYCLES));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_q <= 32'h0000_0000;
      end else if (conv_q == TCS_IDLE || adc_done || take_temp || take_host || conv_lost) begin
         busy_cnt_q <= 32'h0000_0000;
      end else begin
         busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
      end
   end

   // ****************************************
   // Converter control
   // ****************************************
   // Start strobe and host acknowledge, one cycle each
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_start_q <= 1'b0;
         host_ack_q <= 1'b0;
      end else begin
         adc_start_q <= take_temp | take_host;
         host_ack_q <= take_host;
      end
   end

   // Converter occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_q <= TCS_IDLE;
      end else if (take_temp) begin
         conv_q <= TCS_TEMP;
      end else if (take_host) begin
         conv_q <= TCS_HOST;
      end else if (adc_done || conv_lost) begin
         conv_q <= TCS_IDLE;
      end
   end

   // Channel and kind of the running conversion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_chan_q <= `TCS_CH_LOCAL;
         adc_temp_q <= 1'b0;
      end else if (take_temp) begin
         adc_chan_q <= pick;
         adc_temp_q <= 1'b1;
      end else if (take_host) begin
         adc_temp_q <= 1'b0;
      end
   end

   // ****************************************
   // Result store with offset
   // ****************************************
   logic [RES_W-1:0] corrected;
   logic temp_done;
   assign corrected = RES_W'($signed(adc_result) + temp_offset);
   assign temp_done = adc_done && (conv_q == TCS_TEMP);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_local_q <= '0;
         temp_remote1_q <= '0;
         temp_remote2_q <= '0;
      end else if (temp_done) begin
         case (adc_chan_q)
            `TCS_CH_LOCAL: begin
               temp_local_q <= corrected;
            end
            `TCS_CH_REMOTE1: begin
               temp_remote1_q <= corrected;
            end
            `TCS_CH_REMOTE2: begin
               temp_remote2_q <= corrected;
            end
            default: begin
               temp_local_q <= temp_local_q;
            end
         endcase
      end
   end

   // One-hot strobe naming the result just stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fresh_q <= 3'h0;
      end else if (temp_done) begin
         fresh_q <= 3'h1 << adc_chan_q;
      end else begin
         fresh_q <= 3'h0;
      end
   end

   // ****************************************
   // Output sequence append
   // ****************************************
   // Appending applies in command mode only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         append_q <= 2'h0;
      end else begin
         append_q <= autocycle_mode ? 2'h0 : append_remote;
      end
   end
endmodule
